// [src/vdac_defines.svh]
// Register offsets, field positions, reset values and timing counts of the voice converter.
`ifndef VDAC_DEFINES_SVH
`define VDAC_DEFINES_SVH

`define VDAC_ADDR_W          2
`define VDAC_OFS_DATA_HIGH   2'h0
`define VDAC_OFS_DATA_LOW    2'h1
`define VDAC_OFS_CONTROL     2'h2
`define VDAC_OFS_STATUS      2'h3
`define VDAC_BYTE_RESET      8'h00
`define VDAC_WORD_RESET      16'h0000
`define VDAC_BIT_RESET       1'h0
`define VDAC_ON_BIT          0
`define VDAC_SETTLE_NS       1000
`define VDAC_CLK_PERIOD_NS   4
`define VDAC_SETTLE_CYCLES   ((`VDAC_SETTLE_NS + `VDAC_CLK_PERIOD_NS - 1) / `VDAC_CLK_PERIOD_NS)
`define VDAC_CNT_W           12

`endif

// [src/vdac_pkg.sv]
// Types shared by the voice converter register front end.
`default_nettype none
package vdac_pkg;

    typedef enum logic [0:0]
    {
        VDAC_OFF_type_s  = 1'b0,
        VDAC_ON_type_s   = 1'b1
    } vdac_power_type;

    typedef struct packed
    {
        logic [7:0]  high_byte;
        logic [7:0]  low_byte;
        logic [7:0]  shadow_byte;
        logic        dac_on;
        logic [15:0] conv_word;
        logic        conv_load;
        logic [7:0]  read_data;
    } vdac_regs_type;

    typedef struct packed
    {
        vdac_power_type  power;
        logic [11:0]     count;
        logic            settled;
    } vdac_settle_type;

endpackage : vdac_pkg
`default_nettype wire

// [src/vdac_settle.sv]
// Settling timer that reports when the converter is stable after being switched on.
`timescale 1ns/100ps
`default_nettype none
`include "vdac_defines.svh"

module vdac_settle
#(
    parameter int SETTLE_CYCLES = `VDAC_SETTLE_CYCLES
)
(
    input  wire logic  clk,
    input  wire logic  reset,
    input  wire logic  dac_on,
    output var  logic  settled
);

    vdac_pkg::vdac_settle_type state_reg;
    vdac_pkg::vdac_settle_type state_next;

    localparam logic [`VDAC_CNT_W-1:0] LAST = `VDAC_CNT_W'(SETTLE_CYCLES - 1);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg.power)
            vdac_pkg::VDAC_OFF_type_s:
            begin
                state_next.count   = '0;
                state_next.settled = 1'h0;
                if (dac_on)
                begin
                    state_next.power = vdac_pkg::VDAC_ON_type_s;
                end
            end
            vdac_pkg::VDAC_ON_type_s:
            begin
                if (!dac_on)
                begin
                    state_next.power   = vdac_pkg::VDAC_OFF_type_s;
                    state_next.settled = 1'h0;
                    state_next.count   = '0;
                end
                else if (state_reg.count == LAST)
                begin
                    state_next.settled = 1'h1;
                end
                else
                begin
                    state_next.count = state_reg.count + 1'h1;
                end
            end
            default:
            begin
                state_next.power = vdac_pkg::VDAC_OFF_type_s;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= '{vdac_pkg::VDAC_OFF_type_s, '0, 1'h0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign settled = state_reg.settled;

endmodule : vdac_settle
`default_nettype wire

// [src/vdac_regs.sv]
// Register front end of the 16-bit voice converter.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "vdac_defines.svh"

module vdac_regs
#(
    parameter int SETTLE_CYCLES = `VDAC_SETTLE_CYCLES
)
(
    input  wire logic                    MCLK,
    input  wire logic                    RESET,
    input  wire logic [`VDAC_ADDR_W-1:0] ADDR,
    input  wire logic [7:0]              WDATA,
    input  wire logic                    WR,
    input  wire logic                    RD,
    output var  logic [7:0]              RDATA,
    output var  logic [15:0]             DAC_WORD,
    output var  logic                    DAC_LOAD,
    output var  logic                    DAC_ON
);

    localparam vdac_pkg::vdac_regs_type REGS_RESET = '{
        high_byte   : `VDAC_BYTE_RESET,
        low_byte    : `VDAC_BYTE_RESET,
        shadow_byte : `VDAC_BYTE_RESET,
        dac_on      : `VDAC_BIT_RESET,
        conv_word   : `VDAC_WORD_RESET,
        conv_load   : `VDAC_BIT_RESET,
        read_data   : `VDAC_BYTE_RESET
    };

    vdac_pkg::vdac_regs_type regs_reg;
    vdac_pkg::vdac_regs_type regs_next;
    logic                    settled;

    function automatic logic hit(input logic [`VDAC_ADDR_W-1:0] a,
                                 input logic [`VDAC_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    vdac_settle
    #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    )
    u_settle
    (
        .clk     (MCLK),
        .reset   (RESET),
        .dac_on  (regs_reg.dac_on),
        .settled (settled)
    );

    always_comb
    begin
        regs_next           = regs_reg;
        regs_next.conv_load = 1'h0;
        regs_next.read_data = `VDAC_BYTE_RESET;
        if (WR)
        begin
            if (hit(ADDR, `VDAC_OFS_DATA_LOW))
            begin
                regs_next.shadow_byte = WDATA;
            end
            if (hit(ADDR, `VDAC_OFS_DATA_HIGH))
            begin
                regs_next.high_byte = WDATA;
                regs_next.low_byte = regs_reg.shadow_byte;
                regs_next.conv_word = {WDATA, regs_reg.shadow_byte};
                regs_next.conv_load = 1'h1;
            end
            if (hit(ADDR, `VDAC_OFS_CONTROL))
            begin
                regs_next.dac_on = WDATA[`VDAC_ON_BIT];
            end
        end
        if (RD)
        begin
            if (hit(ADDR, `VDAC_OFS_DATA_HIGH))
            begin
                regs_next.read_data = regs_reg.high_byte;
            end
            else if (hit(ADDR, `VDAC_OFS_DATA_LOW))
            begin
                regs_next.read_data = regs_reg.low_byte;
            end
            else if (hit(ADDR, `VDAC_OFS_CONTROL))
            begin
                regs_next.read_data = {7'h00, regs_reg.dac_on};
            end
            else
            begin
                regs_next.read_data = {7'h00, settled};
            end
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            regs_reg <= REGS_RESET;
        end
        else
        begin
            regs_reg <= regs_next;
        end
    end

    assign RDATA    = regs_reg.read_data;
    assign DAC_WORD = regs_reg.conv_word;
    assign DAC_LOAD = regs_reg.conv_load;
    assign DAC_ON   = regs_reg.dac_on;

endmodule : vdac_regs
`default_nettype wire

// [bench/vdac_chk.sv]
// Checker of the voice converter register front end.
`timescale 1ns/100ps
`default_nettype none
module vdac_chk
(
    input wire logic        MCLK,
    input wire logic        RESET,
    input wire logic [1:0]  ADDR,
    input wire logic [7:0]  WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    input wire logic [15:0] DAC_WORD,
    input wire logic        DAC_LOAD,
    input wire logic        DAC_ON
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    property p_load; WR && ADDR == 2'h0 |=> DAC_LOAD && DAC_WORD[15:8] == $past(WDATA); endproperty
    a_load: assert property (p_load) else $error("no load");
    property p_hold; !DAC_LOAD |-> $stable(DAC_WORD); endproperty
    a_hold: assert property (p_hold) else $error("word moved");
    property p_on; WR && ADDR == 2'h2 |=> DAC_ON == $past(WDATA[0]); endproperty
    a_on: assert property (p_on) else $error("enable");
    property p_ctl; RD && ADDR == 2'h2 |=> RDATA == {7'h00, DAC_ON}; endproperty
    a_ctl: assert property (p_ctl) else $error("control read");
    property p_hi; RD && ADDR == 2'h0 |=> RDATA == DAC_WORD[15:8]; endproperty
    a_hi: assert property (p_hi) else $error("high read");
    property p_lo; RD && ADDR == 2'h1 |=> RDATA == DAC_WORD[7:0]; endproperty
    a_lo: assert property (p_lo) else $error("low read");
    property p_low; WR && ADDR == 2'h1 |=> !DAC_LOAD && $stable(DAC_WORD); endproperty
    a_low: assert property (p_low) else $error("low write moved word");
    property p_src; DAC_LOAD |-> $past(WR) && $past(ADDR) == 2'h0; endproperty
    a_src: assert property (p_src) else $error("load without high write");
    property p_rst; disable iff (1'h0) RESET |=> DAC_WORD == 16'h0000 && !DAC_ON; endproperty
    a_rst: assert property (p_rst) else $error("reset");
endmodule : vdac_chk
bind vdac_regs vdac_chk u_chk (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .DAC_WORD(DAC_WORD), .DAC_LOAD(DAC_LOAD),
    .DAC_ON(DAC_ON));
`default_nettype wire

// [bench/vdac_ladder.sv]
// Behavioural ladder and amplifier that turn the committed word into a level.
`timescale 1ns/100ps
`default_nettype none
module vdac_ladder
(
    input  wire logic        clk,
    input  wire logic [15:0] word,
    input  wire logic        load,
    input  wire logic        power,
    output var  logic [15:0] level
);
    logic [15:0] held_reg;
    always_ff @(posedge clk)
    begin
        if (load)
            held_reg <= word;
    end
    assign level = power ? held_reg : 16'h0000;
endmodule : vdac_ladder
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench of the voice converter register front end.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        mclk = 1'h0;
    logic        reset = 1'h1;
    logic [1:0]  addr = 2'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'h0;
    logic        rd = 1'h0;
    logic [7:0]  rdata;
    logic [15:0] word;
    logic        load;
    logic        dac_on;
    logic [15:0] level;
    int          errors = 0;
    int          total_checks = 0;
    initial forever #2 mclk = ~mclk;
    vdac_regs #(.SETTLE_CYCLES(4)) dut (.MCLK(mclk), .RESET(reset), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .DAC_WORD(word),
        .DAC_LOAD(load), .DAC_ON(dac_on));
    vdac_ladder u_ladder (.clk(mclk), .word(word), .load(load), .power(dac_on), .level(level));
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'h0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
        @(posedge mclk);
        rd <= 1'h1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'h0;
        #1;
        check("rdata", {8'h00, rdata}, {8'h00, e});
    endtask : rd_reg
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (4) @(posedge mclk);
        reset <= 1'h0;
        for (int i = 0; i < 4; i++)
            rd_reg(i[1:0], 8'h00);
        check("on", {15'h0000, dac_on}, 16'h0000);
        wr_reg(2'h2, 8'hFF);
        check("on", {15'h0000, dac_on}, 16'h0001);
        rd_reg(2'h3, 8'h00);
        rd_reg(2'h2, 8'h01);
        repeat (8) @(posedge mclk);
        rd_reg(2'h3, 8'h01);
        wr_reg(2'h1, 8'h34);
        check("word", word, 16'h0000);
        check("load", {15'h0000, load}, 16'h0000);
        rd_reg(2'h1, 8'h00);
        wr_reg(2'h0, 8'h12);
        check("load", {15'h0000, load}, 16'h0001);
        check("word", word, 16'h1234);
        rd_reg(2'h1, 8'h34);
        check("load", {15'h0000, load}, 16'h0000);
        rd_reg(2'h0, 8'h12);
        check("level", level, 16'h1234);
        wr_reg(2'h0, 8'hAB);
        check("word", word, 16'hAB34);
        wr_reg(2'h2, 8'h00);
        check("level", level, 16'h0000);
        rd_reg(2'h3, 8'h00);
        wr_reg(2'h2, 8'h01);
        wr_reg(2'h1, 8'h56);
        @(posedge mclk);
        reset <= 1'h1;
        repeat (2) @(posedge mclk);
        reset <= 1'h0;
        #1;
        check("word", word, 16'h0000);
        check("on", {15'h0000, dac_on}, 16'h0000);
        rd_reg(2'h0, 8'h00);
        rd_reg(2'h1, 8'h00);
        wr_reg(2'h0, 8'h78);
        check("word", word, 16'h7800);
        report_and_stop();
    end
    initial
    begin
        repeat (2000) @(posedge mclk);
        errors++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
